/* hw/mode_and_reset_control.sv */
`timescale 1ns/1ps
module mode_and_reset_control
   import mode_reset_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   // board, analog and watchdog sources
   input  wire logic        reset_pin_n_i,
   input  wire logic        mode_pin_high_i,
   input  wire logic        mode_pin_low_i,
   input  wire logic        low_volt_level0_i,
   input  wire logic        low_volt_level1_i,
   input  wire logic        watchdog_ovf_i,
   // cpu side
   input  wire logic        cpu_flags_we_i,
   input  wire logic        cpu_trace_i,
   input  wire logic        cpu_irq_mask_i,
   // AHB-Lite slave
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output logic [31:0]      hrdata_o,
   // outputs to the chip
   output logic             int_reset_o,
   output logic             reset_exc_start_o,
   output logic             trace_bit_o,
   output logic             irq_mask_o,
   output logic [2:0]       op_mode_o,
   output logic             mode_valid_o,
   output logic [1:0]       irq_ctl_mode_o,
   output logic             nonmaskable_edge_sel_o,
   output logic             onchip_ram_on_o,
   output logic [2:0]       i2c_rate_ext_o,
   output logic [1:0]       timer_clk_pick_o
);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [4:0]  sync1;
      logic [4:0]  sync2;
      logic        in_reset;
      logic        exc_start;
      logic        trace;
      logic        irq_mask;
      logic        lat_held;
      logic        lat_hi;
      logic        lat_lo;
      logic        mdc_rsv7;
      logic        mdc_rsv3;
      logic [1:0]  sys_rsv;
      logic        intm_lo;
      logic        last_reset_origin;
      logic        nonmaskable_edge_sel;
      logic        sys_rsv1;
      logic        onchip_ram_on;
      logic [7:0]  serial_timer_control;
      logic        f_pin;
      logic        f_lv1;
      logic        f_pon;
      logic        f_wdt;
      logic        wr_pend;
      logic        rd_pend;
      logic [15:0] acc_idx;
      logic [31:0] rdata;
   } state_t;

   localparam state_t ST_RESET = '{
      sync1: SYN_RST, sync2: SYN_RST, in_reset: 1'b0, exc_start: 1'b0,
      trace: 1'b0, irq_mask: 1'b1, lat_held: 1'b0, lat_hi: 1'b0,
      lat_lo: 1'b0, mdc_rsv7: 1'b0, mdc_rsv3: 1'b0,
      sys_rsv: SYS_CTL_RST[SYS_RSV_MSB:SYS_RSV_LSB],
      intm_lo: SYS_CTL_RST[SYS_INTM_LO], last_reset_origin: SYS_CTL_RST[SYS_LAST_RESET_ORIGIN],
      nonmaskable_edge_sel: SYS_CTL_RST[SYS_NONMASKABLE_EDGE_SEL], sys_rsv1: SYS_CTL_RST[SYS_RSV_1],
      onchip_ram_on: SYS_CTL_RST[SYS_ONCHIP_RAM_ON], serial_timer_control: SER_TMR_RST,
      f_pin: RESET_CAUSE_RST[RCF_PIN], f_lv1: RESET_CAUSE_RST[RCF_LV1],
      f_pon: RESET_CAUSE_RST[RCF_PON], f_wdt: RESET_CAUSE_RST[RCF_WDT],
      wr_pend: 1'b0, rd_pend: 1'b0, acc_idx: 16'h0000,
      rdata: 32'h0000_0000
   };

   state_t      s_q;
   state_t      s_d;
   logic        src_pin;
   logic        src_pon;
   logic        src_lv1;
   logic        src_wdt;
   logic        any_src;
   logic        acc;
   logic        hit;
   logic [15:0] idx;
   logic        rd_now;
   logic [7:0]  rd_val;

   // ****************************************************************
   // next-state logic
   // ****************************************************************
   always_comb begin
      s_d = s_q;

      // pins from the board and analog detectors cross into clk_i
      s_d.sync1 = {mode_pin_high_i, mode_pin_low_i, low_volt_level1_i,
                   low_volt_level0_i, reset_pin_n_i};
      s_d.sync2 = s_q.sync1;

      // reset sources; watchdog already runs on this clock
      src_pin = !s_q.sync2[SYN_PIN_N];
      src_pon = s_q.sync2[SYN_LV0];
      src_lv1 = s_q.sync2[SYN_LV1];
      src_wdt = watchdog_ovf_i;
      any_src = src_pin | src_pon | src_lv1 | src_wdt;

      // address phase decode; zero wait states so hready is always high
      acc    = hsel_i & hready_i & htrans_i[HTRANS_ACTIVE];
      hit    = (haddr_i[31:18] == 14'h0000);
      idx    = hit ? haddr_i[17:2] : 16'h0000;
      rd_now = acc & !hwrite_i;
      s_d.wr_pend = acc & hwrite_i;
      s_d.rd_pend = rd_now;
      s_d.acc_idx = idx;

      // data phase of a write; writes during internal reset are lost
      if (s_q.wr_pend && !s_q.in_reset) begin
         case (s_q.acc_idx)
            IDX_MODE_CTL: begin
               // latch bits 2:1 are not writable here
               s_d.mdc_rsv7 = hwdata_i[MDC_RSV_HI];
               s_d.mdc_rsv3 = hwdata_i[MDC_RSV_LO];
            end
            IDX_SYS_CTL: begin
               s_d.sys_rsv  = hwdata_i[SYS_RSV_MSB:SYS_RSV_LSB];
               // upper mode bit is read-only, so 1x never appears
               s_d.intm_lo  = hwdata_i[SYS_INTM_LO];
               s_d.nonmaskable_edge_sel    = hwdata_i[SYS_NONMASKABLE_EDGE_SEL];
               s_d.sys_rsv1 = hwdata_i[SYS_RSV_1];
               s_d.onchip_ram_on     = hwdata_i[SYS_ONCHIP_RAM_ON];
            end
            IDX_SER_TMR: s_d.serial_timer_control = hwdata_i[7:0];
            IDX_RESET_CAUSE: begin
               // a zero clears, a one keeps the flag
               s_d.f_pin = s_q.f_pin & hwdata_i[RCF_PIN];
               s_d.f_lv1 = s_q.f_lv1 & hwdata_i[RCF_LV1];
               s_d.f_pon = s_q.f_pon & hwdata_i[RCF_PON];
               s_d.f_wdt = s_q.f_wdt & hwdata_i[RCF_WDT];
            end
            default: ;
         endcase
      end

      // a read of mode_control catches the settled pin levels
      if (rd_now && idx == IDX_MODE_CTL) begin
         s_d.lat_held = 1'b1;
         s_d.lat_hi   = s_q.sync2[SYN_MD_HI];
         s_d.lat_lo   = s_q.sync2[SYN_MD_LO];
      end

      // cpu may change its own trace and mask bits outside reset
      if (cpu_flags_we_i) begin
         s_d.trace    = cpu_trace_i;
         s_d.irq_mask = cpu_irq_mask_i;
      end

      // internal reset overrides the bus: sources set flags last, so a
      // cause is never lost to a clear in the same cycle
      s_d.in_reset  = any_src;
      s_d.exc_start = s_q.in_reset & !any_src;
      if (any_src) begin
         s_d.trace    = 1'b0;
         s_d.irq_mask = 1'b1;
         s_d.lat_held = 1'b0;
         s_d.mdc_rsv7 = 1'b0;
         s_d.mdc_rsv3 = 1'b0;
         s_d.sys_rsv  = SYS_CTL_RST[SYS_RSV_MSB:SYS_RSV_LSB];
         s_d.intm_lo  = SYS_CTL_RST[SYS_INTM_LO];
         s_d.nonmaskable_edge_sel    = SYS_CTL_RST[SYS_NONMASKABLE_EDGE_SEL];
         s_d.sys_rsv1 = SYS_CTL_RST[SYS_RSV_1];
         s_d.onchip_ram_on     = SYS_CTL_RST[SYS_ONCHIP_RAM_ON];
         s_d.serial_timer_control     = SER_TMR_RST;
         // first cycle of an episode forgets older causes
         s_d.f_pin = src_pin | (s_q.in_reset & s_q.f_pin);
         s_d.f_lv1 = src_lv1 | (s_q.in_reset & s_q.f_lv1);
         s_d.f_pon = src_pon | (s_q.in_reset & s_q.f_pon);
         s_d.f_wdt = src_wdt | (s_q.in_reset & s_q.f_wdt);
         s_d.last_reset_origin  = s_d.f_pin | s_d.f_lv1 | s_d.f_pon;
      end

      // read data built from the updated state, so a read right after a
      // write to the same register sees the new value
      rd_val = 8'h00;
      unique case (idx)
         IDX_MODE_CTL: begin
            rd_val[MDC_RSV_HI] = s_d.mdc_rsv7;
            rd_val[MDC_RSV_LO] = s_d.mdc_rsv3;
            rd_val[MDC_LAT_HI] = s_d.lat_hi;
            rd_val[MDC_LAT_LO] = s_d.lat_lo;
         end
         IDX_SYS_CTL: begin
            rd_val[SYS_RSV_MSB:SYS_RSV_LSB] = s_d.sys_rsv;
            rd_val[SYS_INTM_LO] = s_d.intm_lo;
            rd_val[SYS_LAST_RESET_ORIGIN]    = s_d.last_reset_origin;
            rd_val[SYS_NONMASKABLE_EDGE_SEL]   = s_d.nonmaskable_edge_sel;
            rd_val[SYS_RSV_1]   = s_d.sys_rsv1;
            rd_val[SYS_ONCHIP_RAM_ON]    = s_d.onchip_ram_on;
         end
         IDX_SER_TMR: rd_val = s_d.serial_timer_control;
         IDX_RESET_CAUSE: begin
            rd_val[RCF_PIN] = s_d.f_pin;
            rd_val[RCF_LV1] = s_d.f_lv1;
            rd_val[RCF_PON] = s_d.f_pon;
            rd_val[RCF_WDT] = s_d.f_wdt;
         end
         default: rd_val = 8'h00;
      endcase
      s_d.rdata = rd_now ? {24'h00_0000, rd_val} : 32'h0000_0000;
   end

   // single register of the whole state
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         s_q <= ST_RESET;
      end else begin
         s_q <= s_d;
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   // bus never stalls and never errors
   assign hreadyout_o       = 1'b1;
   assign hresp_o           = 1'b0;
   assign hrdata_o          = s_q.rdata;
   assign int_reset_o       = s_q.in_reset;
   assign reset_exc_start_o = s_q.exc_start;
   assign trace_bit_o       = s_q.trace;
   assign irq_mask_o        = s_q.irq_mask;

   // pin patterns 01, 10, 11 read straight out as modes 2, 4, 6
   // unlatched mode follows the settled pins; lowest bit is tied low
   always_comb begin
      op_mode_o[2] = s_q.lat_held ? s_q.lat_hi : s_q.sync2[SYN_MD_HI];
      op_mode_o[1] = s_q.lat_held ? s_q.lat_lo : s_q.sync2[SYN_MD_LO];
      op_mode_o[0] = 1'b0;
   end
   // pins 00 would mean mode 0, which does not exist
   assign mode_valid_o = op_mode_o[2] | op_mode_o[1];

   assign irq_ctl_mode_o         = {1'b0, s_q.intm_lo};
   assign nonmaskable_edge_sel_o = s_q.nonmaskable_edge_sel;
   assign onchip_ram_on_o        = s_q.onchip_ram_on;
   assign i2c_rate_ext_o   = s_q.serial_timer_control[STC_I2C_MSB:STC_I2C_LSB];
   assign timer_clk_pick_o = s_q.serial_timer_control[STC_TMR_MSB:STC_TMR_LSB];

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i);

   AST_MODE_VALID: assert property (
      mode_valid_o |-> (op_mode_o == MODE_SINGLE || op_mode_o == MODE_FLASH
                        || op_mode_o == MODE_EMUL))
      else $error("decoded mode outside 2, 4, 6");

   AST_MODE_ZERO: assert property (
      op_mode_o[0] == 1'b0 && (mode_valid_o == (op_mode_o != 3'h0)))
      else $error("lowest mode bit not zero");

   AST_LATCH_ON_READ: assert property (
      (rd_now && idx == IDX_MODE_CTL && !any_src) |=>
         (op_mode_o[2:1] == $past(s_q.sync2[SYN_MD_HI:SYN_MD_LO]))
         ##1 ($stable(op_mode_o) || $past(any_src)))
      else $error("mode latch missed the read");

   AST_LATCH_NO_WRITE: assert property (
      (s_q.wr_pend && s_q.acc_idx == IDX_MODE_CTL && s_q.lat_held
       && !rd_now && !any_src) |=> $stable(op_mode_o))
      else $error("write changed the mode latch");

   AST_MDC_ZERO_BITS: assert property (
      (rd_now && idx == IDX_MODE_CTL) |=>
         (hrdata_o[6:4] == 3'h0 && hrdata_o[0] == 1'b0
          && hrdata_o[31:8] == 24'h00_0000))
      else $error("mode_control zero bits read nonzero");

   AST_INTM_HI_ZERO: assert property (
      irq_ctl_mode_o[1] == 1'b0)
      else $error("prohibited interrupt control mode");

   AST_RESET_DEFAULTS: assert property (
      any_src |=> (onchip_ram_on_o && !nonmaskable_edge_sel_o
                   && i2c_rate_ext_o == 3'h0 && irq_mask_o && !trace_bit_o))
      else $error("control bits not reset");

   AST_RESET_HOLD: assert property (
      $fell(reset_pin_n_i) |-> ##3 int_reset_o)
      else $error("pin reset not taken in three cycles");

   AST_EXC_START: assert property (
      (int_reset_o && !any_src) |=> (reset_exc_start_o && !int_reset_o)
         ##1 !reset_exc_start_o)
      else $error("exception start pulse wrong");

   AST_PIN_FLAG: assert property (
      (src_pin && !src_pon && !src_lv1 && !src_wdt && !s_q.in_reset)
         |=> (s_q.f_pin && !s_q.f_pon && !s_q.f_lv1 && !s_q.f_wdt
              && s_q.last_reset_origin))
      else $error("pin reset flags wrong");

   AST_FLAG_CLEAR: assert property (
      (s_q.wr_pend && s_q.acc_idx == IDX_RESET_CAUSE && !s_q.in_reset
       && !any_src && !hwdata_i[RCF_PIN]) |=> !s_q.f_pin)
      else $error("zero write did not clear flag");

   // a watchdog-only reset must report itself through the source bit
   AST_WDT_SOURCE: assert property (
      (src_wdt && !src_pin && !src_pon && !src_lv1 && !s_q.in_reset)
         |=> (!s_q.last_reset_origin && s_q.f_wdt && !s_q.f_pin))
      else $error("watchdog reset source wrong");

   AST_SOURCE_TAKEN: assert property (
      any_src |=> int_reset_o)
      else $error("reset source not taken");

   // the start pulse may only follow the end of an internal reset
   AST_EXC_AFTER_RESET: assert property (
      reset_exc_start_o |-> ($past(int_reset_o) && !int_reset_o))
      else $error("exception start without reset");

   AST_FLAG_ZERO_BITS: assert property (
      (rd_now && idx == IDX_RESET_CAUSE) |=>
         (hrdata_o[7:5] == 3'h0 && hrdata_o[3] == 1'b0))
      else $error("flag zero bits read nonzero");

   // a write reaches the RAM enable unless a reset overrides it
   AST_RAM_WRITE: assert property (
      (s_q.wr_pend && s_q.acc_idx == IDX_SYS_CTL && !s_q.in_reset
       && !any_src) |=> (onchip_ram_on_o == $past(hwdata_i[SYS_ONCHIP_RAM_ON])))
      else $error("RAM enable write lost");

endmodule

/* hw/mode_reset_pkg.sv */
package mode_reset_pkg;

   // register indices; the byte address on the bus is four times the index
   localparam logic [15:0] IDX_RESET_CAUSE = 16'hfb40;
   localparam logic [15:0] IDX_MODE_CTL    = 16'hff90;
   localparam logic [15:0] IDX_SYS_CTL     = 16'hff91;
   localparam logic [15:0] IDX_SER_TMR     = 16'hff9e;

   // reset values
   localparam logic [7:0]  SYS_CTL_RST     = 8'h09;
   localparam logic [7:0]  SER_TMR_RST     = 8'h00;
   localparam logic [7:0]  RESET_CAUSE_RST = 8'h10;

   // mode_control fields
   localparam int MDC_RSV_HI  = 7;
   localparam int MDC_RSV_LO  = 3;
   localparam int MDC_LAT_HI  = 2;
   localparam int MDC_LAT_LO  = 1;

   // system_control fields
   localparam int SYS_RSV_MSB = 7;
   localparam int SYS_RSV_LSB = 6;
   localparam int SYS_INTM_HI = 5;
   localparam int SYS_INTM_LO = 4;
   localparam int SYS_LAST_RESET_ORIGIN    = 3;
   localparam int SYS_NONMASKABLE_EDGE_SEL   = 2;
   localparam int SYS_RSV_1   = 1;
   localparam int SYS_ONCHIP_RAM_ON    = 0;

   // serial_timer_control fields
   localparam int STC_I2C_MSB = 7;
   localparam int STC_I2C_LSB = 5;
   localparam int STC_TMR_MSB = 1;
   localparam int STC_TMR_LSB = 0;

   // reset_cause_flags fields
   localparam int RCF_PIN     = 4;
   localparam int RCF_LV1     = 2;
   localparam int RCF_PON     = 1;
   localparam int RCF_WDT     = 0;

   // positions in the pin synchroniser vector
   localparam int SYN_PIN_N   = 0;
   localparam int SYN_LV0     = 1;
   localparam int SYN_LV1     = 2;
   localparam int SYN_MD_LO   = 3;
   localparam int SYN_MD_HI   = 4;
   localparam logic [4:0] SYN_RST = 5'h01;

   // decoded operating modes
   localparam logic [2:0] MODE_SINGLE = 3'h2;
   localparam logic [2:0] MODE_FLASH  = 3'h4;
   localparam logic [2:0] MODE_EMUL   = 3'h6;

   // AHB transfer type bit that marks NONSEQ or SEQ
   localparam int HTRANS_ACTIVE = 1;

endpackage

/* sim/board_model.sv */
`timescale 1ns/1ps
// ************************************************
// board strapping and external reset driver
// ************************************************
module board_model (
   input  wire logic       clk_i,
   input  wire logic       pin_req_i,
   input  wire logic [1:0] strap_i,
   input  wire logic       lv0_req_i,
   input  wire logic       lv1_req_i,
   output logic            reset_pin_n_o,
   output logic            mode_pin_high_o,
   output logic            mode_pin_low_o,
   output logic            low_volt_level0_o,
   output logic            low_volt_level1_o
);
   logic [4:0] low_cnt_q = 5'h00;

   // a short request still keeps the pin low for 20 cycles after it ends
   always @(posedge clk_i) begin
      if (pin_req_i) begin
         low_cnt_q <= 5'h14;
      end else if (low_cnt_q != 5'h00) begin
         low_cnt_q <= low_cnt_q - 5'h01;
      end
   end

   // pin stays high while the power-on source is in use
   assign reset_pin_n_o = lv0_req_i ? 1'b1 :
                          !(pin_req_i || low_cnt_q != 5'h00);
   // strapping is static; the bench picks mode 2 for normal running
   assign mode_pin_high_o   = strap_i[1];
   assign mode_pin_low_o    = strap_i[0];
   assign low_volt_level0_o = lv0_req_i;
   assign low_volt_level1_o = lv1_req_i;
endmodule

/* sim/mode_and_reset_control_tb_top.sv */
`timescale 1ns/1ps
module mode_and_reset_control_tb_top;
   import mode_reset_pkg::*;
   logic        clk_i;
   logic        reset_n_i = 1'b0;
   logic        pin_req   = 1'b0;
   logic        lv0_req   = 1'b0;
   logic        lv1_req   = 1'b0;
   logic        wdt       = 1'b0;
   logic [1:0]  strap     = 2'h1;
   logic        we        = 1'b0;
   logic        trc       = 1'b0;
   logic        msk       = 1'b1;
   logic        hsel      = 1'b0;
   logic        hwrite    = 1'b0;
   logic [1:0]  htrans    = 2'h0;
   logic [31:0] haddr     = 32'h0000_0000;
   logic [31:0] hwdata    = 32'h0000_0000;
   logic        rd_pend   = 1'b0;
   logic        hready, hresp, pin_n, md_hi, md_lo, lv0, lv1;
   logic        int_rst, exc, trace, mask, mvalid, nm_edge, ram_on;
   logic [31:0] hrdata;
   logic [2:0]  op_mode, i2c;
   logic [1:0]  irq_mode, tmr;
   logic [31:0] rd_q[$];
   logic [31:0] r;
   logic [7:0]  flag_exp [4] = '{8'h02, 8'h04, 8'h01, 8'h10};
   int          errors, check_count;
   int          seed = 32'h8ee7_0b85;

   board_model brd (.clk_i(clk_i), .pin_req_i(pin_req), .strap_i(strap),
      .lv0_req_i(lv0_req), .lv1_req_i(lv1_req), .reset_pin_n_o(pin_n),
      .mode_pin_high_o(md_hi), .mode_pin_low_o(md_lo),
      .low_volt_level0_o(lv0), .low_volt_level1_o(lv1));

   mode_and_reset_control dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
      .reset_pin_n_i(pin_n), .mode_pin_high_i(md_hi), .mode_pin_low_i(md_lo),
      .low_volt_level0_i(lv0), .low_volt_level1_i(lv1),
      .watchdog_ovf_i(wdt), .cpu_flags_we_i(we), .cpu_trace_i(trc),
      .cpu_irq_mask_i(msk), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hready), .hreadyout_o(hready),
      .hresp_o(hresp), .hrdata_o(hrdata), .int_reset_o(int_rst),
      .reset_exc_start_o(exc), .trace_bit_o(trace), .irq_mask_o(mask),
      .op_mode_o(op_mode), .mode_valid_o(mvalid),
      .irq_ctl_mode_o(irq_mode), .nonmaskable_edge_sel_o(nm_edge),
      .onchip_ram_on_o(ram_on), .i2c_rate_ext_o(i2c),
      .timer_clk_pick_o(tmr));

   // ************************************************
   // clock, checks and bus tasks
   // ************************************************
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one single transfer; the caller stands just after a rising edge
   task automatic bus(logic wr_en, logic [15:0] idx, logic [31:0] d);
      hsel   <= 1'b1;
      haddr  <= {14'h0000, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= wr_en;
      do @(posedge clk_i); while (hready !== 1'b1);
      htrans  <= 2'h0;
      hwdata  <= d;
      rd_pend <= !wr_en;
      do @(posedge clk_i); while (hready !== 1'b1);
      rd_pend <= 1'b0;
   endtask

   task automatic wr(logic [15:0] idx, logic [31:0] d);
      bus(1'b1, idx, d);
   endtask

   task automatic rd(logic [15:0] idx, logic [31:0] e);
      rd_q.push_back(e);
      bus(1'b0, idx, 32'h0000_0000);
   endtask

   // read data is taken at the edge that closes the data phase
   always @(posedge clk_i) begin
      if (rd_pend === 1'b1 && hready === 1'b1) begin
         chk("read data", rd_q.pop_front(), hrdata);
         chk("response", 32'h0000_0000, {31'h0, hresp});
      end
   end

   // bounded wait: a pin reset lingers 20 cycles plus synchroniser delay
   task automatic wait_exc();
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (exc !== 1'b1 && n < 60);
      chk("exception start", 32'h1, exc);
      chk("internal reset", 32'h0, int_rst);
      @(posedge clk_i);
      chk("exception start", 32'h0, exc);
   endtask

   // hang guard, far beyond the few hundred cycles the tests need
   initial begin
      repeat (20000) @(posedge clk_i);
      errors++;
      close_out();
   end

   // ************************************************
   // test sequence
   // ************************************************
   initial begin
      repeat (12) @(posedge clk_i);
      reset_n_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rd(IDX_RESET_CAUSE, 32'h10);
      rd(IDX_SYS_CTL, 32'h09);
      rd(IDX_SER_TMR, 32'h00);
      rd(16'h0040, 32'h00);
      chk("ram enable", 32'h1, ram_on);
      chk("irq mask", 32'h1, mask);
      chk("trace", 32'h0, trace);
      $display("test reset values done");
      for (int p = 1; p < 5; p++) begin
         strap <= p[1:0];
         repeat (4) @(posedge clk_i);
         rd(IDX_MODE_CTL, {29'h0, p[1:0], 1'b0});
         @(posedge clk_i);
         chk("operating mode", {p[1:0], 1'b0}, op_mode);
         chk("mode valid", p < 4, mvalid);
      end
      strap <= 2'h2;
      repeat (6) @(posedge clk_i);
      chk("latched mode", 32'h0, op_mode);
      strap <= 2'h1;
      $display("test mode decode done");
      for (int k = 0; k < 4; k++) begin
         wr(IDX_SYS_CTL, 32'hd6);
         // the I2C channels and timers are taken as out of module stop
         wr(IDX_SER_TMR, 32'he3);
         we  <= 1'b1;
         trc <= 1'b1;
         msk <= 1'b0;
         @(posedge clk_i);
         we <= 1'b0;
         @(posedge clk_i);
         chk("trace", 32'h1, trace);
         chk("irq mask", 32'h0, mask);
         {pin_req, wdt, lv1_req, lv0_req} <= 4'(4'h1 << k);
         repeat (8) @(posedge clk_i);
         chk("internal reset", 32'h1, int_rst);
         chk("trace", 32'h0, trace);
         chk("irq mask", 32'h1, mask);
         {pin_req, wdt, lv1_req, lv0_req} <= 4'h0;
         wait_exc();
         rd(IDX_RESET_CAUSE, flag_exp[k]);
         rd(IDX_SYS_CTL, k == 2 ? 32'h01 : 32'h09);
         rd(IDX_SER_TMR, 32'h00);
      end
      chk("released mode", 32'h2, op_mode);
      $display("test reset sources done");
      for (int i = 0; i < 4; i++) begin
         r = $random(seed);
         wr(IDX_MODE_CTL, r);
         rd(IDX_MODE_CTL, {24'h0, r[7], 3'h0, r[3], 3'h2});
         wr(IDX_SYS_CTL, r);
         rd(IDX_SYS_CTL, {24'h0, r[7:6], 1'b0, r[4], 1'b1, r[2:0]});
         chk("irq mode", {1'b0, r[4]}, irq_mode);
         chk("nmi edge", r[2], nm_edge);
         chk("ram enable", r[0], ram_on);
         wr(IDX_SER_TMR, r);
         rd(IDX_SER_TMR, {24'h0, r[7:0]});
         chk("i2c rate", r[7:5], i2c);
         chk("timer clock", r[1:0], tmr);
      end
      $display("test register access done");
      wr(IDX_RESET_CAUSE, 32'hff);
      rd(IDX_RESET_CAUSE, 32'h10);
      wr(IDX_RESET_CAUSE, 32'h00);
      rd(IDX_RESET_CAUSE, 32'h00);
      $display("test flag clearing done");
      repeat (2) @(posedge clk_i);
      close_out();
   end
endmodule
